/* File: rtl/dcpwm_pkg.sv */
// Constants shared by the dual channel pulse width unit
package dcpwm_pkg;
    localparam int unsigned DCPWM_CH = 2;
    localparam int unsigned DCPWM_AW = 3;
    localparam int unsigned DCPWM_DW = 16;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [2:0] OFS_CTRL = 3'h0;
    localparam logic [2:0] OFS_PRESC = 3'h1;
    localparam logic [2:0] OFS_WIDTH0 = 3'h2;
    localparam logic [2:0] OFS_WIDTH1 = 3'h3;
    localparam logic [2:0] OFS_PDIR = 3'h4;
    localparam logic [2:0] OFS_PLATCH = 3'h5;
    localparam logic [2:0] OFS_PULLUP = 3'h6;
    // ----------------------------------------
    // Control field layout, per channel stride
    // ----------------------------------------
    localparam int unsigned CTRL_LEVEL = 0;
    localparam int unsigned CTRL_EN = 1;
    localparam int unsigned CTRL_STRIDE = 2;
    localparam int unsigned CTRL_SYNC = 4;
    localparam int unsigned PRESC_STRIDE = 2;
    // ----------------------------------------
    // Reset values and write masks
    // ----------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h05;
    localparam logic [7:0] CTRL_MASK = 8'h3f;
    localparam logic [7:0] PRESC_RST = 8'h00;
    localparam logic [7:0] PRESC_MASK = 8'h0f;
    localparam logic [1:0] PDIR_RST = 2'h3;
    localparam logic [1:0] PLATCH_RST = 2'h0;
    localparam logic PULLUP_RST = 1'b0;
    // ----------------------------------------
    // Width field layout and cycle figures
    // ----------------------------------------
    localparam int unsigned WID_BASE_LSB = 8;
    localparam int unsigned WID_EXT_LSB = 4;
    localparam logic [7:0] CYC_LAST = 8'hff;
    localparam logic [3:0] GRP_LAST = 4'hf;
    localparam logic [1:0] PRE_ZERO = 2'h0;
endpackage

/* File: rtl/dcpwm_unit.sv */
// Dual channel 12-bit pulse width output unit with port fallback
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module dcpwm_unit
    import dcpwm_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [DCPWM_AW-1:0] regAddr,
    input wire logic [DCPWM_DW-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DCPWM_DW-1:0] regRdata,
    output logic [DCPWM_CH-1:0] pinOut,
    output logic [DCPWM_CH-1:0] pinOe,
    output logic [DCPWM_CH-1:0] pinPullUp
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [3:0] bitRev4(input logic [3:0] v);
        bitRev4 = {v[0], v[1], v[2], v[3]};
    endfunction

    // Active clocks in one basic cycle: base plus one extra if picked
    function automatic logic [8:0] activeLen(input logic [15:0] w, input logic [3:0] grp);
        logic addOne;
        addOne = 1'b0;
        addOne = (bitRev4(grp) <= w[WID_EXT_LSB +: 4]);
        activeLen = {1'b0, w[WID_BASE_LSB +: 8]} + {8'h00, addOne};
    endfunction

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [7:0] ctrl_r;
    logic [7:0] presc_r;
    logic [15:0] width_r [DCPWM_CH];
    logic [1:0] pDir_r;
    logic [1:0] pLatch_r;
    logic pullUp_r;
    logic [DCPWM_DW-1:0] regRdata_r;

    wire logic wrCtrl = regWr && (regAddr == OFS_CTRL);
    wire logic wrPresc = regWr && (regAddr == OFS_PRESC);
    wire logic wrW0 = regWr && (regAddr == OFS_WIDTH0);
    wire logic wrW1 = regWr && (regAddr == OFS_WIDTH1);
    wire logic wrDir = regWr && (regAddr == OFS_PDIR);
    wire logic wrLatch = regWr && (regAddr == OFS_PLATCH);
    wire logic wrPull = regWr && (regAddr == OFS_PULLUP);

    logic [DCPWM_DW-1:0] rdMux;
    always_comb begin
        rdMux = '0;
        unique case (regAddr)
            OFS_CTRL: rdMux = {8'h00, ctrl_r};
            OFS_PRESC: rdMux = {8'h00, presc_r};
            OFS_WIDTH0: rdMux = width_r[0];
            OFS_WIDTH1: rdMux = width_r[1];
            OFS_PDIR: rdMux = {14'h0000, pDir_r};
            OFS_PLATCH: rdMux = {14'h0000, pLatch_r};
            OFS_PULLUP: rdMux = {15'h0000, pullUp_r};
            default: rdMux = '0;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= CTRL_RST;
            presc_r <= PRESC_RST;
            pDir_r <= PDIR_RST;
            pLatch_r <= PLATCH_RST;
            pullUp_r <= PULLUP_RST;
            regRdata_r <= '0;
        end else begin
            if (wrCtrl) begin
                ctrl_r <= regWdata[7:0] & CTRL_MASK;
            end
            if (wrPresc) begin
                presc_r <= regWdata[7:0] & PRESC_MASK;
            end
            if (wrDir) begin
                pDir_r <= regWdata[1:0];
            end
            if (wrLatch) begin
                pLatch_r <= regWdata[1:0];
            end
            if (wrPull) begin
                pullUp_r <= regWdata[0];
            end
            regRdata_r <= regRd ? rdMux : '0;
        end
    end

    // No reset on purpose: contents are undefined until software loads them
    always_ff @(posedge clk) begin
        if (wrW0) begin
            width_r[0] <= regWdata;
        end
        if (wrW1) begin
            width_r[1] <= regWdata;
        end
    end

    assign regRdata = regRdata_r;

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    logic [DCPWM_CH-1:0] pinOut_r;
    logic [DCPWM_CH-1:0] pinOe_r;
    logic [DCPWM_CH-1:0] pinPullUp_r;

    for (genvar c = 0; c < DCPWM_CH; c++) begin : gCh
        wire logic chEn = ctrl_r[c*CTRL_STRIDE + CTRL_EN];
        wire logic chLevel = ctrl_r[c*CTRL_STRIDE + CTRL_LEVEL];
        wire logic chSync = ctrl_r[CTRL_SYNC + c];
        wire logic [1:0] divSel = presc_r[c*PRESC_STRIDE +: 2];

        logic [1:0] pre_r;
        logic [7:0] down_r;
        logic [3:0] grp_r;
        logic [15:0] act_r;
        logic run_r;

        // Divide by divSel+1; tick is the unit clock enable
        wire logic tick = (pre_r == divSel);
        wire logic cycEnd = tick && (down_r == 8'h00);
        wire logic grpEnd = cycEnd && (grp_r == GRP_LAST);
        // Sync off: new width only at group edge, else every basic cycle
        wire logic reload = chSync ? cycEnd : grpEnd;
        wire logic [3:0] grpNxt = grp_r + 4'h1;
        wire logic [8:0] len = activeLen(act_r, grp_r);
        // Elapsed clocks in cycle is 255 minus the down count
        wire logic pwmOn = run_r && ({1'b0, ~down_r} < len);

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                pre_r <= PRE_ZERO;
                down_r <= CYC_LAST;
                grp_r <= 4'h0;
                act_r <= 16'h0000;
                run_r <= 1'b0;
            end else if (!chEn) begin
                // Stop at once; next enable begins a fresh group
                pre_r <= PRE_ZERO;
                down_r <= CYC_LAST;
                grp_r <= 4'h0;
                run_r <= 1'b0;
            end else if (!run_r) begin
                // Start lines up with a group edge by opening one here
                act_r <= width_r[c];
                run_r <= 1'b1;
            end else if (tick) begin
                pre_r <= PRE_ZERO;
                down_r <= down_r - 8'h01;
                if (cycEnd) begin
                    down_r <= CYC_LAST;
                    grp_r <= grpNxt;
                end
                if (reload) begin
                    act_r <= width_r[c];
                end
            end else begin
                pre_r <= pre_r + 2'h1;
            end
        end

        // Pin from level and port settings, all registered
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                pinOut_r[c] <= 1'b0;
                pinOe_r[c] <= 1'b0;
                pinPullUp_r[c] <= 1'b0;
            end else if (run_r) begin
                pinOut_r[c] <= chLevel ? pwmOn : ~pwmOn;
                pinOe_r[c] <= 1'b1;
                pinPullUp_r[c] <= 1'b0;
            end else begin
                // Level bit unused here, so writing it moves nothing
                pinOut_r[c] <= pLatch_r[c];
                pinOe_r[c] <= ~pDir_r[c];
                pinPullUp_r[c] <= pDir_r[c] & pullUp_r;
            end
        end
    end

    assign pinOut = pinOut_r;
    assign pinOe = pinOe_r;
    assign pinPullUp = pinPullUp_r;

endmodule
`default_nettype wire

/* File: dv/dcpwm_load.sv */
// Load model turning the pulse unit pins into wire levels
`timescale 1ns/10ps
`default_nettype none
module dcpwm_load (
    input wire logic clk,
    input wire logic [1:0] pinOut,
    input wire logic [1:0] pinOe,
    input wire logic [1:0] pinPullUp,
    output logic [1:0] pinLevel
);
    logic [1:0] lastR = 2'h0;
    // Floating pin without pull-up shows the inverse of its last level, so stale data cannot pass; with pull-up it reads high
    assign pinLevel = (pinOe & pinOut) | (~pinOe & (pinPullUp | ~lastR));
    always_ff @(posedge clk) begin
        lastR <= pinLevel;
    end
endmodule
`default_nettype wire

/* File: dv/dcpwm_unit_checker.sv */
// Port checker for the dual channel pulse unit
`timescale 1ns/10ps
`default_nettype none
module dcpwm_unit_checker
    import dcpwm_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [DCPWM_AW-1:0] regAddr,
    input wire logic [DCPWM_DW-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [DCPWM_DW-1:0] regRdata,
    input wire logic [DCPWM_CH-1:0] pinOut,
    input wire logic [DCPWM_CH-1:0] pinOe,
    input wire logic [DCPWM_CH-1:0] pinPullUp
);
    logic [7:0] ctrlR;
    logic [7:0] prescR;
    logic [1:0] dirR;
    logic [1:0] latchR;
    logic puR;
    logic [1:0] quietR;
    // ----
    // Shadow registers; pins judged only three clocks after any write
    // ----
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrlR <= CTRL_RST;
            prescR <= PRESC_RST;
            dirR <= PDIR_RST;
            latchR <= PLATCH_RST;
            puR <= PULLUP_RST;
            quietR <= 2'h0;
        end else begin
            quietR <= regWr ? 2'h0 : quietR + {1'b0, quietR != 2'h3};
            if (regWr) begin
                case (regAddr)
                    OFS_CTRL: ctrlR <= regWdata[7:0] & CTRL_MASK;
                    OFS_PRESC: prescR <= regWdata[7:0] & PRESC_MASK;
                    OFS_PDIR: dirR <= regWdata[1:0];
                    OFS_PLATCH: latchR <= regWdata[1:0];
                    OFS_PULLUP: puR <= regWdata[0];
                    default: ;
                endcase
            end
        end
    end
    wire [1:0] en = {ctrlR[3], ctrlR[1]};
    wire quiet = quietR == 2'h3;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    read_idle_a: assert property (!regRd |=> regRdata == 16'h0)
        else $error("read data not idle");
    ctrl_read_a: assert property (regRd && regAddr == OFS_CTRL |=> regRdata == {8'h0, $past(ctrlR)})
        else $error("control read wrong");
    presc_read_a: assert property (regRd && regAddr == OFS_PRESC |=> regRdata == {8'h0, $past(prescR)})
        else $error("prescale read wrong");
    unmapped_read_a: assert property (regRd && regAddr == 3'h7 |=> regRdata == 16'h0)
        else $error("unmapped read not zero");
    port_drive_a: assert property (quiet |-> (pinOe & ~en) == (~dirR & ~en))
        else $error("port enable wrong");
    port_latch_a: assert property (quiet |-> (pinOut & ~en & ~dirR) == (latchR & ~en & ~dirR))
        else $error("port latch not driven");
    port_pull_a: assert property (quiet |-> (pinPullUp & ~en) == (dirR & {2{puR}} & ~en))
        else $error("pull-up wrong");
    run_drive_a: assert property (quiet |-> (pinOe & en) == en && (pinPullUp & en) == 2'h0)
        else $error("enabled pin not driven");
    cover property (regRd && regAddr == OFS_CTRL);
    cover property (quiet && en[0]);
    cover property (quiet && !en[0] && !dirR[0]);
endmodule
bind dcpwm_unit dcpwm_unit_checker u_chk (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pinOut(pinOut), .pinOe(pinOe), .pinPullUp(pinPullUp));
`default_nettype wire

/* File: dv/dcpwm_unit_tb.sv */
// Self-checking bench for the dual channel pulse unit
`timescale 1ns/10ps
`default_nettype none
module dcpwm_unit_tb
    import dcpwm_pkg::*;
;
    typedef struct {logic wr; logic [2:0] a; logic [15:0] d;} dcpwm_row_s;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [15:0] regWdata = 16'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regRdata;
    logic [1:0] pinOut, pinOe, pinPullUp, pinLevel;
    int bad_count = 0;
    int check_count = 0;
    // Reads expect d, writes send it
    dcpwm_row_s rows [12] = '{'{1'b0, OFS_CTRL, 16'h0005}, '{1'b0, OFS_PRESC, 16'h0000},
        '{1'b1, OFS_PRESC, 16'h00ff}, '{1'b0, OFS_PRESC, 16'h000f}, '{1'b1, OFS_WIDTH0, 16'h1234},
        '{1'b0, OFS_WIDTH0, 16'h1234}, '{1'b1, OFS_WIDTH1, 16'hffff}, '{1'b0, OFS_WIDTH1, 16'hffff},
        '{1'b1, 3'h7, 16'habcd}, '{1'b0, 3'h7, 16'h0000}, '{1'b1, OFS_CTRL, 16'h00f0}, '{1'b0, OFS_CTRL, 16'h0030}};
    dcpwm_unit u_dcpwm_unit (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .pinOut(pinOut), .pinOe(pinOe), .pinPullUp(pinPullUp));
    dcpwm_load u_dcpwm_load (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pinPullUp(pinPullUp), .pinLevel(pinLevel));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        d = regRdata;
    endtask
    // Counts active clocks of channel 0 over exactly one 16-cycle group
    task automatic duty(input logic [7:0] pre, input logic [15:0] w, input logic [7:0] ctl, input int n, input int exp);
        int cnt;
        int k;
        cnt = 0;
        k = 0;
        wr(OFS_PRESC, {8'h0, pre});
        wr(OFS_WIDTH0, w);
        wr(OFS_CTRL, {8'h0, ctl});
        while (pinOe[0] !== 1'b1) begin
            @(negedge clk);
            k++;
            if (k > 20) begin
                bad_count++;
                final_report();
            end
        end
        for (int i = 0; i < n; i++) begin
            cnt += int'(pinLevel[0] === ctl[0]);
            @(negedge clk);
        end
        check(cnt[15:0], exp[15:0]);
        wr(OFS_CTRL, 16'h0000);
    endtask
    initial begin
        logic [15:0] d;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].a, rows[i].d);
            end else begin
                rd(rows[i].a, d);
                check(d, rows[i].d);
            end
        end
        duty(8'h00, 16'h1000, 8'h03, 4096, 257);
        duty(8'h01, 16'h1234, 8'h03, 8192, 584);
        duty(8'h00, 16'h0100, 8'h02, 4096, 17);
        duty(8'h03, 16'hfff0, 8'h12, 16384, 16384);
        // Both channels mid-pulse, then flip both levels while enabled
        wr(OFS_WIDTH0, 16'h8000);
        wr(OFS_WIDTH1, 16'h8000);
        wr(OFS_CTRL, 16'h000f);
        repeat (4) @(negedge clk);
        check({14'h0, pinLevel}, 16'h0003);
        wr(OFS_CTRL, 16'h000a);
        repeat (2) @(negedge clk);
        check({14'h0, pinLevel}, 16'h0000);
        wr(OFS_CTRL, 16'h0000);
        wr(OFS_PDIR, 16'h0002);
        wr(OFS_PLATCH, 16'h0001);
        wr(OFS_PULLUP, 16'h0001);
        repeat (4) @(negedge clk);
        check({12'h0, pinOe, pinLevel}, 16'h0007);
        wr(OFS_CTRL, 16'h0004);
        repeat (4) @(negedge clk);
        check({12'h0, pinPullUp, pinLevel}, 16'h000b);
        @(posedge clk);
        nrst <= 1'b0;
        @(negedge clk);
        check({12'h0, pinOe, pinPullUp}, 16'h0000);
        @(posedge clk);
        nrst <= 1'b1;
        rd(OFS_CTRL, d);
        check(d, 16'h0005);
        final_report();
    end
endmodule
`default_nettype wire
